// file: hdl/lac_pkg.sv
// constants and field layout for the channel alarm and interrupt status block
package lac_pkg;
  localparam int NUM_CH = 8;
  localparam int CH_BITS = 3;
  localparam int NUM_SEG = 8;
  localparam int SEG_BITS = 3;
  localparam int SEG_W = 7;

  // per-channel offsets, replicated at a stride of 0x10
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'h4;
  localparam logic [3:0] OFF_ALARM_DETECT = 4'h5;
  localparam logic [3:0] OFF_CHANGE_LATCH = 4'h6;
  localparam logic [3:0] OFF_SEG_FIRST = 4'h8;
  localparam logic [7:0] CH_SPACE_END = 8'h80;

  // global registers
  localparam logic [7:0] GIE_ADDR_DEFAULT = 8'he0;
  localparam int GIE_BIT = 0;
  localparam logic [7:0] OVF_SEL_ADDR = 8'h81;
  localparam int OVF_SEL_BIT = 7;

  // bit positions inside enable, detect and change registers, and the segment sign bit
  localparam int BIT_VIOLATION = 4;
  localparam int BIT_ALL_ONES = 2;
  localparam int BIT_LOSS = 1;
  localparam int BIT_PATTERN = 0;
  localparam int SEG_SIGN_BIT = 6;

  // index of each condition in the monitor's 4-bit vectors
  localparam int IDX_PATTERN = 0;
  localparam int IDX_LOSS = 1;
  localparam int IDX_ALL_ONES = 2;
  localparam int IDX_VIOLATION = 3;

  // writable bits of the enable register (bits 7 and 3 unused)
  localparam logic [7:0] IRQ_ENABLE_MASK = 8'h77;

  // values after reset, and the value read at unmapped addresses
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [3:0] COND_RST = 4'h0;
  localparam logic [SEG_W-1:0] SEG_RST = 7'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// file: hdl/lac_chan_if.sv
// carrier between the top and each channel's alarm monitor
`timescale 1ns/1ps
`default_nettype none
interface lac_chan_if;
  logic [3:0] cond;
  logic [3:0] detect;
  logic [3:0] latch;
  logic clr;

  modport mon (
    input cond,
    input clr,
    output detect,
    output latch
  );

  modport top (
    output cond,
    output clr,
    input detect,
    input latch
  );
endinterface
`default_nettype wire

// file: hdl/lac_chan_mon.sv
// one channel: live detection bits and their change-of-status latches
`timescale 1ns/1ps
`default_nettype none
module lac_chan_mon (
  input wire logic sys_clk_i, // system clock
  input wire logic sys_rst_i, // synchronous reset, high
  lac_chan_if.mon port        // conditions in, detect and latch out
);
  logic [3:0] detect_q;
  logic [3:0] detect_d;
  logic [3:0] latch_q;
  logic [3:0] latch_d;
  logic [3:0] changed;

  // detection follows the condition whatever the enables say
  assign detect_d = port.cond;
  assign changed = detect_d ^ detect_q;
  // a change in the clearing cycle survives the read
  assign latch_d = (port.clr ? lac_pkg::COND_RST : latch_q) | changed;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      detect_q <= lac_pkg::COND_RST;
      latch_q <= lac_pkg::COND_RST;
    end else begin
      detect_q <= detect_d;
      latch_q <= latch_d;
    end
  end

  assign port.detect = detect_q;
  assign port.latch = latch_q;
endmodule
`default_nettype wire

// file: hdl/lac_seg_mem.sv
// arbitrary pulse segment store, one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module lac_seg_mem (
  input wire logic sys_clk_i,                   // system clock
  input wire logic sys_rst_i,                   // synchronous reset, high
  input wire logic wr_en_i,                     // write strobe
  input wire logic [5:0] wr_addr_i,             // {channel, segment}
  input wire logic [lac_pkg::SEG_W-1:0] wr_data_i, // segment value
  input wire logic [5:0] a_addr_i,              // bus read address
  output logic [lac_pkg::SEG_W-1:0] a_data_o,   // bus read data
  input wire logic [5:0] b_addr_i,              // shaper read address
  output logic [lac_pkg::SEG_W-1:0] b_data_o    // shaper read data
);
  localparam int DEPTH = lac_pkg::NUM_CH * lac_pkg::NUM_SEG;

  logic [lac_pkg::SEG_W-1:0] mem_q [DEPTH];

  // reset clears every segment, so the store is flops rather than ram
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= lac_pkg::SEG_RST;
      end
      a_data_o <= lac_pkg::SEG_RST;
      b_data_o <= lac_pkg::SEG_RST;
    end else begin
      if (wr_en_i) begin
        mem_q[wr_addr_i] <= wr_data_i;
      end
      a_data_o <= mem_q[a_addr_i];
      b_data_o <= mem_q[b_addr_i];
    end
  end
endmodule
`default_nettype wire

// file: hdl/lac_alarm_irq_top.sv
// eight-channel alarm reporting, change-of-status interrupt and pulse segments
//
// Behaviour
// - violation bit shows line violations, or counter overflow when overflow select set
// - violation bit is one after violation, bipolar violation or excessive zeros
// - all-ones alarm bit is one while all-ones receive signal is seen
// - live detection bits track conditions whatever the interrupt enables hold
// - loss-of-signal bit is one while receive loss of signal is present
// - pattern bit is one while the test pattern is locked
// - a condition interrupts only with its channel enable and global enable set
// - interrupt pin needs global enable besides the channel enable bits
// - change bit sets when its detection bit changes state
// - reading the change register clears its latched bits
// - any enabled change raises interrupt when global enable is one
// - arbitrary pulse is built from eight programmable segments per channel
// - first segment register holds the overshoot segment
// - four segments shape the pulse top, four the bottom
// - segment five holds the undershoot portion
// - segment bit 6 is sign: zero negative, one positive
// - enable bits mask at zero, permit at one, reset to zero
`timescale 1ns/1ps
`default_nettype none
module lac_alarm_irq_top #(
  parameter logic [7:0] GLOBAL_EN_ADDR = lac_pkg::GIE_ADDR_DEFAULT // global enable location
) (
  input wire logic sys_clk_i,                              // system clock, 250 MHz
  input wire logic sys_rst_i,                              // synchronous reset, high
  input wire logic [7:0] addr_i,                           // register address
  input wire logic [7:0] wdata_i,                          // write data
  input wire logic cs_i,                                   // chip select, high
  input wire logic wr_i,                                   // write strobe, high
  input wire logic rd_i,                                   // read strobe, high
  output logic [7:0] rdata_o,                              // read data
  output logic rvalid_o,                                   // read data valid pulse
  input wire logic [lac_pkg::NUM_CH-1:0] line_code_violation_i, // violation activity
  input wire logic [lac_pkg::NUM_CH-1:0] counter_overflow_i,    // violation counter overflow
  input wire logic [lac_pkg::NUM_CH-1:0] all_ones_alarm_i,      // all-ones receive signal
  input wire logic [lac_pkg::NUM_CH-1:0] receive_signal_loss_i, // receive loss of signal
  input wire logic [lac_pkg::NUM_CH-1:0] quasi_random_pattern_i, // test pattern lock
  input wire logic [lac_pkg::CH_BITS-1:0] seg_ch_i,        // shaper channel select
  input wire logic [lac_pkg::SEG_BITS-1:0] seg_idx_i,      // shaper segment, 0 is first
  output logic [lac_pkg::SEG_W-2:0] seg_magnitude_o,       // segment amplitude
  output logic seg_positive_o,                             // segment direction, 1 positive
  output logic irq_n_o                                     // interrupt pin, low active
);
  localparam int NC = lac_pkg::NUM_CH;

  // decode of a channel-space offset, used by the enable, detect and change registers (segments use hit_seg)
  function automatic logic chan_hit(input logic [7:0] a, input logic [3:0] off);
    chan_hit = (a < lac_pkg::CH_SPACE_END) && (a[3:0] == off);
  endfunction

  // map the monitor's condition order onto the register bit layout
  function automatic logic [7:0] place_bits(input logic [3:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[lac_pkg::BIT_VIOLATION] = v[lac_pkg::IDX_VIOLATION];
    r[lac_pkg::BIT_ALL_ONES] = v[lac_pkg::IDX_ALL_ONES];
    r[lac_pkg::BIT_LOSS] = v[lac_pkg::IDX_LOSS];
    r[lac_pkg::BIT_PATTERN] = v[lac_pkg::IDX_PATTERN];
    place_bits = r;
  endfunction

  // pull the four monitored enables back out of the enable register
  function automatic logic [3:0] pick_bits(input logic [7:0] r);
    logic [3:0] v;
    v = 4'h0;
    v[lac_pkg::IDX_VIOLATION] = r[lac_pkg::BIT_VIOLATION];
    v[lac_pkg::IDX_ALL_ONES] = r[lac_pkg::BIT_ALL_ONES];
    v[lac_pkg::IDX_LOSS] = r[lac_pkg::BIT_LOSS];
    v[lac_pkg::IDX_PATTERN] = r[lac_pkg::BIT_PATTERN];
    pick_bits = v;
  endfunction

  // bus request decode
  wire wr_take = cs_i && wr_i;
  wire rd_take = cs_i && rd_i && !wr_i;
  wire [lac_pkg::CH_BITS-1:0] chan_sel = addr_i[6:4];
  wire hit_enable = chan_hit(addr_i, lac_pkg::OFF_IRQ_ENABLE);
  wire hit_detect = chan_hit(addr_i, lac_pkg::OFF_ALARM_DETECT);
  wire hit_latch = chan_hit(addr_i, lac_pkg::OFF_CHANGE_LATCH);
  // offsets 0x8..0xf of each channel hold segments one to eight
  wire hit_seg = (addr_i < lac_pkg::CH_SPACE_END) && addr_i[3];
  wire hit_gie = (addr_i == GLOBAL_EN_ADDR);
  wire hit_ovf = (addr_i == lac_pkg::OVF_SEL_ADDR);
  wire [5:0] seg_bus_addr = {chan_sel, addr_i[2:0]};

  // global controls
  logic global_irq_enable_q;
  logic ovf_select_q;

  // per-channel enable registers
  logic [7:0] irq_enable_q [NC];

  // monitor results gathered per channel
  logic [3:0] detect_w [NC];
  logic [3:0] latch_w [NC];
  logic [NC-1:0] chan_pending;

  // read pipeline
  logic [7:0] rd_stage_q;
  logic rd_mem_q;
  logic rd_busy_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic irq_n_q;
  logic [lac_pkg::SEG_W-1:0] seg_bus_data;
  logic [lac_pkg::SEG_W-1:0] seg_shaper_data;

  lac_chan_if ch_if [NC] ();

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : gen_ch
      wire sel_me = (chan_sel == (lac_pkg::CH_BITS)'(g));
      wire en_wr = wr_take && hit_enable && sel_me;
      wire [3:0] en_bits = pick_bits(irq_enable_q[g]);

      // violation source chosen by the global overflow select
      assign ch_if[g].cond[lac_pkg::IDX_VIOLATION] =
        ovf_select_q ? counter_overflow_i[g] : line_code_violation_i[g];
      assign ch_if[g].cond[lac_pkg::IDX_ALL_ONES] = all_ones_alarm_i[g];
      assign ch_if[g].cond[lac_pkg::IDX_LOSS] = receive_signal_loss_i[g];
      assign ch_if[g].cond[lac_pkg::IDX_PATTERN] = quasi_random_pattern_i[g];
      // clear lands on the same edge that samples the old value for the reply
      assign ch_if[g].clr = rd_take && hit_latch && sel_me;

      lac_chan_mon u_mon (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .port(ch_if[g])
      );

      assign detect_w[g] = ch_if[g].detect;
      assign latch_w[g] = ch_if[g].latch;
      // latched change gated by its enable bit
      assign chan_pending[g] = |(latch_w[g] & en_bits);

      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          irq_enable_q[g] <= lac_pkg::IRQ_ENABLE_RST;
        end else if (en_wr) begin
          irq_enable_q[g] <= wdata_i & lac_pkg::IRQ_ENABLE_MASK;
        end
      end
    end
  endgenerate

  // global enable and overflow select registers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      global_irq_enable_q <= 1'b0;
      ovf_select_q <= 1'b0;
    end else if (wr_take) begin
      if (hit_gie) begin
        global_irq_enable_q <= wdata_i[lac_pkg::GIE_BIT];
      end
      if (hit_ovf) begin
        ovf_select_q <= wdata_i[lac_pkg::OVF_SEL_BIT];
      end
    end
  end

  // segment store: eight 7-bit segments per channel, bit 6 the sign
  lac_seg_mem u_seg (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(wr_take && hit_seg),
    .wr_addr_i(seg_bus_addr),
    .wr_data_i(wdata_i[lac_pkg::SEG_W-1:0]),
    .a_addr_i(seg_bus_addr),
    .a_data_o(seg_bus_data),
    .b_addr_i({seg_ch_i, seg_idx_i}),
    .b_data_o(seg_shaper_data)
  );

  // shaper sees sign and magnitude split out
  assign seg_positive_o = seg_shaper_data[lac_pkg::SEG_SIGN_BIT];
  assign seg_magnitude_o = seg_shaper_data[lac_pkg::SEG_W-2:0];

  // read value selection for everything outside the segment store
  logic [7:0] glob_word;
  logic [7:0] reg_word;
  always_comb begin
    glob_word = lac_pkg::UNMAPPED_READ;
    if (hit_gie) begin
      glob_word[lac_pkg::GIE_BIT] = global_irq_enable_q;
    end
    if (hit_ovf) begin
      glob_word[lac_pkg::OVF_SEL_BIT] = ovf_select_q;
    end
  end

  always_comb begin
    if (hit_enable) begin
      reg_word = irq_enable_q[chan_sel];
    end else if (hit_detect) begin
      reg_word = place_bits(detect_w[chan_sel]);
    end else if (hit_latch) begin
      reg_word = place_bits(latch_w[chan_sel]);
    end else begin
      reg_word = glob_word;
    end
  end

  // reads: sample at the request edge, reply one edge later
  // the segment store adds its own register stage, hence the two-step reply
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rd_stage_q <= lac_pkg::RDATA_RST;
      rd_mem_q <= 1'b0;
      rd_busy_q <= 1'b0;
    end else begin
      rd_busy_q <= rd_take;
      if (rd_take) begin
        rd_stage_q <= reg_word;
        rd_mem_q <= hit_seg;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= lac_pkg::RDATA_RST;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_busy_q;
      if (rd_busy_q) begin
        // bit 7 of a segment word is unused and reads zero
        rdata_q <= rd_mem_q ? {1'b0, seg_bus_data} : rd_stage_q;
      end
    end
  end

  // interrupt pin: any enabled latch on any channel, qualified globally
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= !(global_irq_enable_q && (|chan_pending));
    end
  end

  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign irq_n_o = irq_n_q;
endmodule
`default_nettype wire

// file: tb/lac_alarm_irq_props.sv
// concurrent checks on the register bus and interrupt pin of the alarm block
`timescale 1ns/1ps
`default_nettype none
module lac_alarm_irq_props #(
  parameter logic [7:0] GLOBAL_EN_ADDR = 8'he0 // global enable location
) (
  input wire logic sys_clk_i, // clock
  input wire logic sys_rst_i, // reset
  input wire logic [7:0] addr_i, // address
  input wire logic cs_i, // select
  input wire logic wr_i, // write
  input wire logic rd_i, // read
  input wire logic [7:0] rdata_o, // read data
  input wire logic rvalid_o, // read valid
  input wire logic [7:0] line_code_violation_i, // condition
  input wire logic [7:0] counter_overflow_i, // condition
  input wire logic [7:0] all_ones_alarm_i, // condition
  input wire logic [7:0] receive_signal_loss_i, // condition
  input wire logic [7:0] quasi_random_pattern_i, // condition
  input wire logic irq_n_o // interrupt pin
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic [39:0] conds = {line_code_violation_i, counter_overflow_i, all_ones_alarm_i,
    receive_signal_loss_i, quasi_random_pattern_i};
  wire logic unmapped = addr_i[7] ? (addr_i != GLOBAL_EN_ADDR && addr_i != 8'h81)
    : (addr_i[3:0] < 4'h4 || addr_i[3:0] == 4'h7);
  sequence rd_take;
    cs_i && rd_i && !wr_i;
  endsequence
  sequence rd_at(logic [3:0] off);
    cs_i && rd_i && !wr_i && !addr_i[7] && addr_i[3:0] == off;
  endsequence
  read_reply_a: assert property (rd_take |-> ##2 rvalid_o)
    else $error("read reply missing");
  reply_cause_a: assert property (rvalid_o |-> $past(cs_i && rd_i && !wr_i, 2))
    else $error("reply without read");
  data_hold_a: assert property (!rvalid_o |-> $stable(rdata_o))
    else $error("read data moved without reply");
  unmapped_zero_a: assert property (rd_take ##0 unmapped |-> ##2 rdata_o == 8'h00)
    else $error("unmapped read not zero");
  enable_mask_a: assert property (rd_at(4'h4) |-> ##2 (rdata_o & 8'h88) == 8'h00)
    else $error("unused enable bits read one");
  status_mask_a: assert property ((rd_at(4'h5) or rd_at(4'h6)) |->
    ##2 (rdata_o & 8'he8) == 8'h00)
    else $error("unused status bits read one");
  seg_top_a: assert property (rd_take ##0 (!addr_i[7] && addr_i[3]) |-> ##2 !rdata_o[7])
    else $error("segment bit 7 read one");
  // enable writes act in two edges, overflow select one edge later
  irq_fall_a: assert property ($fell(irq_n_o) |-> $past(cs_i && wr_i, 2)
    || $past(cs_i && wr_i, 3) || $past(conds, 2) != $past(conds, 3))
    else $error("interrupt without cause");
  irq_rise_a: assert property ($rose(irq_n_o) |-> $past(cs_i && (rd_i || wr_i), 2))
    else $error("interrupt released without access");
  reset_quiet_a: assert property (disable iff (1'b0) sys_rst_i |=> irq_n_o && !rvalid_o)
    else $error("pin or reply active in reset");
endmodule
bind lac_alarm_irq_top lac_alarm_irq_props #(.GLOBAL_EN_ADDR(GLOBAL_EN_ADDR)) i_props (
  .sys_clk_i, .sys_rst_i, .addr_i, .cs_i, .wr_i, .rd_i, .rdata_o, .rvalid_o,
  .line_code_violation_i, .counter_overflow_i, .all_ones_alarm_i,
  .receive_signal_loss_i, .quasi_random_pattern_i, .irq_n_o);
`default_nettype wire

// file: tb/test_lac_alarm_irq_top.sv
// self-checking bench for the alarm and interrupt status block
`timescale 1ns/1ps
`default_nettype none
module test_lac_alarm_irq_top;
  localparam logic [7:0] GEN = 8'he0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [4:0][7:0] cnd = '0;
  logic [2:0] sch = 3'h0;
  logic [2:0] sidx = 3'h0;
  logic [7:0] rdata;
  logic [5:0] smag;
  logic rvalid, spos, irq_n;
  logic [7:0] en_m [8];
  logic [7:0] det_m [8];
  logic [7:0] lat_m [8];
  logic [6:0] seg_m [64];
  logic gie_m, ovf_m, irq_m, any_m;
  logic [7:0] nd;
  logic [31:0] rv;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 32'h7bd4981c;

  lac_alarm_irq_top #(.GLOBAL_EN_ADDR(GEN)) i_dut (.sys_clk_i(clk), .sys_rst_i(rst),
    .addr_i(addr), .wdata_i(wdata), .cs_i(cs), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .rvalid_o(rvalid), .line_code_violation_i(cnd[0]), .counter_overflow_i(cnd[1]),
    .all_ones_alarm_i(cnd[2]), .receive_signal_loss_i(cnd[3]),
    .quasi_random_pattern_i(cnd[4]), .seg_ch_i(sch), .seg_idx_i(sidx),
    .seg_magnitude_o(smag), .seg_positive_o(spos), .irq_n_o(irq_n));

  always #2 clk = ~clk;

  function automatic logic [7:0] det_of(int c);
    return {3'h0, ovf_m ? cnd[1][c] : cnd[0][c], 1'b0, cnd[2][c], cnd[3][c], cnd[4][c]};
  endfunction

  function automatic logic [7:0] exp_rd(logic [7:0] a);
    if (!a[7]) begin
      case (a[3:0])
        4'h4: return en_m[a[6:4]];
        4'h5: return det_m[a[6:4]];
        4'h6: return lat_m[a[6:4]];
        default: return a[3] ? {1'b0, seg_m[{a[6:4], a[2:0]}]} : 8'h00;
      endcase
    end
    if (a == GEN) return {7'h00, gie_m};
    if (a == 8'h81) return {ovf_m, 7'h00};
    return 8'h00;
  endfunction

  // register file model, updated on the same edges as the block
  always @(posedge clk) begin
    if (rst) begin
      gie_m <= 1'b0;
      ovf_m <= 1'b0;
      irq_m <= 1'b1;
      for (int c = 0; c < 8; c++) begin
        en_m[c] <= 8'h00;
        det_m[c] <= 8'h00;
        lat_m[c] <= 8'h00;
      end
      for (int i = 0; i < 64; i++) seg_m[i] <= 7'h00;
    end else begin
      any_m = 1'b0;
      for (int c = 0; c < 8; c++) begin
        nd = det_of(c);
        any_m = any_m | (|(lat_m[c] & en_m[c]));
        // a change in the clearing cycle still sets
        lat_m[c] <= ((cs && rd && !wr && addr == {1'b0, c[2:0], 4'h6}) ? 8'h00 : lat_m[c])
          | (nd ^ det_m[c]);
        det_m[c] <= nd;
      end
      irq_m <= ~(gie_m & any_m);
      if (cs && wr && !addr[7] && addr[3:0] == 4'h4) en_m[addr[6:4]] <= wdata & 8'h77;
      if (cs && wr && !addr[7] && addr[3]) seg_m[{addr[6:4], addr[2:0]}] <= wdata[6:0];
      if (cs && wr && addr == GEN) gie_m <= wdata[0];
      if (cs && wr && addr == 8'h81) ovf_m <= wdata[7];
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {cs, wr, addr, wdata} = {2'b11, a, d};
    @(negedge clk);
    {cs, wr} = 2'b00;
  endtask

  task automatic rreg(input logic [7:0] a);
    logic [7:0] e;
    @(negedge clk);
    {cs, rd, addr} = {2'b11, a};
    e = exp_rd(a);
    @(negedge clk);
    {cs, rd} = 2'b00;
    // reply stands only in the cycle after the edge that follows the staging edge
    @(posedge clk);
    #1;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, e);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(negedge clk) begin
    if (!rst) chk({7'h00, irq_n}, {7'h00, irq_m});
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles > 12000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int a = 0; a < 256; a++) rreg(a[7:0]);
    for (int a = 0; a < 256; a++) wreg(a[7:0], 8'($random(seed)));
    for (int a = 0; a < 256; a++) rreg(a[7:0]);
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      {sch, sidx} = i[5:0];
      @(posedge clk);
      #1;
      chk({2'b00, smag}, {2'b00, seg_m[i][5:0]});
      chk({7'h00, spos}, {7'h00, seg_m[i][6]});
    end
    wreg(GEN, 8'h01);
    // sparse flips keep conditions stable long enough to see each change
    repeat (600) begin
      rv = $random(seed);
      case (rv[2:0])
        3'h0, 3'h1, 3'h2: begin
          @(negedge clk);
          cnd[rv[7:5] % 5][rv[10:8]] = ~cnd[rv[7:5] % 5][rv[10:8]];
        end
        3'h3: rreg({1'b0, rv[14:12], 4'h6});
        3'h4: rreg({1'b0, rv[14:12], 4'h5});
        3'h5: wreg({1'b0, rv[14:12], 4'h4}, rv[23:16]);
        3'h6: wreg(8'h81, rv[23:16]);
        default: wreg(GEN, {7'h00, rv[20] | rv[21]});
      endcase
    end
    // mid-run reset with live conditions; three edges keep the pin checks quiet
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int c = 0; c < 8; c++) begin
      rreg({1'b0, c[2:0], 4'h4});
      rreg({1'b0, c[2:0], 4'h6});
    end
    rreg(GEN);
    final_report();
  end
endmodule
`default_nettype wire
